// file: mic_pkg.sv
// Purpose: Shared constants and types for the interrupt controller.
// Assumes: 20 MHz clock, four clocks per instruction cycle (Q1..Q4).
// Notes:   Register byte address is four times the register index.
// Function
// - Global enable at control bit 7 gates all requests; reset clears it.
// - Return-from-handler sets the global enable again.
// - Entry clears global enable, pushes return address, loads vector 0004h.
// - Flags set on events regardless of any enable bit.
// - Latency three to four cycles asynchronous, three cycles synchronous.
// - Latency independent of one- or two-cycle current instruction.
// - Clearing global enable inserts a no-op next cycle; requests stay pending.
// - External pin edge sensitive; option bit 6 selects rising when set.
// - Valid external edge sets external flag at control bit 1.
// - External enable at control bit 4 masks the pin interrupt.
// - External interrupt wakes from sleep if enabled before sleep.
// - Timer-0 rollover sets flag bit 2; enable at bit 5.
// - Port B pins 7..4 change sets flag bit 0; enable bit 3.
// - Pin change during a port read may miss the flag; here a change in the read cycle still sets it.
// - External flag sampled each Q1, may set during Q4 through Q1; here a valid edge sets it on any clock.
// - Peripheral flags and enables live in their own two registers.
// - Entry saves only the return address on the stack.
// - Any enabled set flag wakes from sleep even with global enable clear.
package mic_pkg;
  localparam int ADDR_W = 12;
  // Register indices (byte address = index * 4)
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_CTRL   = 10'h00B;
  localparam logic [9:0] IDX_PFLAGS = 10'h00C;
  localparam logic [9:0] IDX_PENAB  = 10'h08C;
  localparam logic [9:0] IDX_STATUS = 10'h010;
  // Reset values
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_PFLAGS = 8'h00;
  localparam logic [7:0] RST_PENAB  = 8'h00;
  localparam logic [7:0] PERIPH_MASK = 8'hF7;
  // Control register bit positions; EDGE_BIT is bit 6 of the option register
  localparam int GIE_BIT  = 7;
  localparam int PGE_BIT  = 6;
  localparam int T0E_BIT  = 5;
  localparam int EXTE_BIT = 4;
  localparam int PCE_BIT  = 3;
  localparam int T0F_BIT  = 2;
  localparam int EXTF_BIT = 1;
  localparam int PCF_BIT  = 0;
  localparam int EDGE_BIT = 6;
  // Instruction cycle phases
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q4 = 2'h3;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DRAIN  = 2'b01,
    ST_DUMMY1 = 2'b10,
    ST_DUMMY2 = 2'b11
  } mic_state_t;

  // Commands to the core sequencer
  typedef struct packed {
    logic        pushRet;
    logic        loadVec;
    logic [12:0] vecAddr;
    logic        dummy;
    logic        nop;
    logic        wake;
    logic        irqReq;
  } mic_core_cmd_t;

  // Synchronous event pulses from core and peripherals
  typedef struct packed {
    logic       timer0Roll;
    logic       retExec;
    logic       gieClrExec;
    logic       portRead;
    logic       sleepActive;
    logic [7:0] periphEvt;
  } mic_core_evt_t;
endpackage : mic_pkg

// file: mic_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Inputs may change at any time.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module mic_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rstnInt,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1_r;

  // One two-flop chain per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
        stage1_r[i] <= 1'b0;
        dout[i]     <= 1'b0;
      end else begin
        stage1_r[i] <= din[i];
        dout[i]     <= stage1_r[i];
      end
    end
  end
endmodule : mic_sync
`default_nettype wire

// file: mic_irq_ctrl.sv
// Purpose: Interrupt controller with AXI4-Lite register access.
// Assumes: Core events are one-clock pulses on clk; pins are asynchronous.
// Notes:   Entry sequence runs on instruction-cycle boundaries (Q1).
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module mic_irq_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  extIrqPin,
  input  wire logic [3:0]            portPins,
  input  wire mic_pkg::mic_core_evt_t coreEvt,
  output mic_pkg::mic_core_cmd_t     coreCmd,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  logic               rstSync0_r;
  logic               rstnInt;
  logic [4:0]         pinSync;
  logic               extPrev_r;
  logic [3:0]         portLatch_r;
  logic [1:0]         qPhase_r;
  mic_pkg::mic_state_t state_r;
  logic [7:0]         optCfg_r;
  logic [7:0]         intrCtl_r;
  logic [7:0]         intrCtl_nxt;
  logic [7:0]         perFlags_r;
  logic [7:0]         perFlags_nxt;
  logic [7:0]         perEnab_r;
  logic               extEnSleep_r;
  logic               sleepPrev_r;
  logic               nopHold_r;
  logic [11:0]        awAddr_r;
  logic               awHeld_r;
  logic [7:0]         wData_r;
  logic               wLane0_r;
  logic               wHeld_r;
  logic               doWrite;
  logic [9:0]         wIdx;
  logic               wrCtl;
  logic               wrFlags;
  logic               extEdge;
  logic               portChange;
  logic               ctlSrc;
  logic               perSrc;
  logic               irqPend;
  logic               take;
  logic               wakeCond;
  logic               gieClrEvt;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync0_r <= 1'b0;
      rstnInt    <= 1'b0;
    end else begin
      rstSync0_r <= 1'b1;
      rstnInt    <= rstSync0_r;
    end
  end

  // Pins into the clock domain
  mic_sync #(.W(5)) u_sync (
    .clk     (clk),
    .rstnInt (rstnInt),
    .din     ({portPins, extIrqPin}),
    .dout    (pinSync)
  );

  // Edge and change detection
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      extPrev_r   <= 1'b0;
      portLatch_r <= 4'h0;
    end else begin
      extPrev_r <= pinSync[0];
      if (coreEvt.portRead) begin
        portLatch_r <= pinSync[4:1]; // A change landing here still sets the flag at this edge
      end
    end
  end

  // Rising when edge select set, else falling
  assign extEdge = optCfg_r[mic_pkg::EDGE_BIT] ? (pinSync[0] & ~extPrev_r)
                                               : (~pinSync[0] & extPrev_r);
  assign portChange = (pinSync[4:1] != portLatch_r);

  // Instruction-cycle phase counter
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      qPhase_r <= mic_pkg::Q1;
    end else begin
      qPhase_r <= qPhase_r + 2'h1;
    end
  end

  // AXI write channel capture, either order
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 12'h000;
      wData_r       <= 8'h00;
      wLane0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mic_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~awHeld_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r  <= 1'b1;
        wData_r  <= s_axi_wdata[7:0];
        wLane0_r <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wIdx == mic_pkg::IDX_OPTION || wIdx == mic_pkg::IDX_CTRL ||
                         wIdx == mic_pkg::IDX_PFLAGS || wIdx == mic_pkg::IDX_PENAB ||
                         wIdx == mic_pkg::IDX_STATUS) ? mic_pkg::RESP_OKAY
                                                      : mic_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign wIdx    = awAddr_r[11:2];
  assign wrCtl   = doWrite & wLane0_r & (wIdx == mic_pkg::IDX_CTRL);
  assign wrFlags = doWrite & wLane0_r & (wIdx == mic_pkg::IDX_PFLAGS);

  // Option and peripheral enable registers
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      optCfg_r  <= mic_pkg::RST_OPTION;
      perEnab_r <= mic_pkg::RST_PENAB;
    end else if (doWrite && wLane0_r) begin
      if (wIdx == mic_pkg::IDX_OPTION) optCfg_r <= wData_r;
      if (wIdx == mic_pkg::IDX_PENAB) perEnab_r <= wData_r & mic_pkg::PERIPH_MASK;
    end
  end

  // Control register next value: write, then hardware; set beats clear, but entry clear beats return set
  always_comb begin
    intrCtl_nxt = wrCtl ? wData_r : intrCtl_r;
    if (coreEvt.gieClrExec) intrCtl_nxt[mic_pkg::GIE_BIT] = 1'b0;
    if (coreEvt.retExec) intrCtl_nxt[mic_pkg::GIE_BIT] = 1'b1;
    if (take) intrCtl_nxt[mic_pkg::GIE_BIT] = 1'b0;
    if (extEdge) intrCtl_nxt[mic_pkg::EXTF_BIT] = 1'b1;
    if (coreEvt.timer0Roll) intrCtl_nxt[mic_pkg::T0F_BIT] = 1'b1;
    if (portChange) intrCtl_nxt[mic_pkg::PCF_BIT] = 1'b1;
    perFlags_nxt = (wrFlags ? wData_r : perFlags_r) |
                   coreEvt.periphEvt;
    perFlags_nxt = perFlags_nxt & mic_pkg::PERIPH_MASK;
  end

  // Flag and control registers; entry leaves flags alone
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      intrCtl_r  <= mic_pkg::RST_CTRL;
      perFlags_r <= mic_pkg::RST_PFLAGS;
    end else begin
      intrCtl_r  <= intrCtl_nxt;
      perFlags_r <= perFlags_nxt;
    end
  end

  // Source gating
  assign ctlSrc = (intrCtl_r[mic_pkg::T0E_BIT] & intrCtl_r[mic_pkg::T0F_BIT]) |
                  (intrCtl_r[mic_pkg::EXTE_BIT] & intrCtl_r[mic_pkg::EXTF_BIT]) |
                  (intrCtl_r[mic_pkg::PCE_BIT] & intrCtl_r[mic_pkg::PCF_BIT]);
  assign perSrc = intrCtl_r[mic_pkg::PGE_BIT] & (|(perFlags_r & perEnab_r));
  assign irqPend = intrCtl_r[mic_pkg::GIE_BIT] & (ctlSrc | perSrc);
  // Taken only on Q1, whatever the current instruction length
  assign take = irqPend & (qPhase_r == mic_pkg::Q1) & (state_r == mic_pkg::ST_IDLE) &
                ~nopHold_r & ~coreEvt.sleepActive;
  assign gieClrEvt = intrCtl_r[mic_pkg::GIE_BIT] & ~intrCtl_nxt[mic_pkg::GIE_BIT] & ~take;
  // External wake uses the enable held at sleep entry
  assign wakeCond = coreEvt.sleepActive &
                    ((extEnSleep_r & intrCtl_r[mic_pkg::EXTF_BIT]) |
                     (intrCtl_r[mic_pkg::T0E_BIT] & intrCtl_r[mic_pkg::T0F_BIT]) |
                     (intrCtl_r[mic_pkg::PCE_BIT] & intrCtl_r[mic_pkg::PCF_BIT]) |
                     perSrc);

  // Enable capture at sleep entry
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      sleepPrev_r  <= 1'b0;
      extEnSleep_r <= 1'b0;
    end else begin
      sleepPrev_r <= coreEvt.sleepActive;
      if (coreEvt.sleepActive && !sleepPrev_r) begin
        extEnSleep_r <= intrCtl_r[mic_pkg::EXTE_BIT];
      end
    end
  end

  // No-op cycle after an instruction clears global enable
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      nopHold_r <= 1'b0;
    end else if (gieClrEvt) begin
      nopHold_r <= 1'b1;
    end else if (qPhase_r == mic_pkg::Q1) begin
      nopHold_r <= 1'b0;
    end
  end

  // Entry sequencer and core commands
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      state_r <= mic_pkg::ST_IDLE;
      coreCmd <= '0;
    end else begin
      coreCmd.pushRet <= 1'b0;
      coreCmd.loadVec <= 1'b0;
      coreCmd.nop     <= nopHold_r & (qPhase_r == mic_pkg::Q1);
      coreCmd.wake    <= wakeCond;
      coreCmd.irqReq  <= irqPend;
      coreCmd.vecAddr <= mic_pkg::VECTOR_ADDR;
      if (qPhase_r == mic_pkg::Q1) begin
        unique case (state_r)
          mic_pkg::ST_IDLE: begin
            if (take) state_r <= mic_pkg::ST_DRAIN;
          end
          mic_pkg::ST_DRAIN: begin
            state_r         <= mic_pkg::ST_DUMMY1;
            coreCmd.pushRet <= 1'b1; // Return address only
            coreCmd.dummy   <= 1'b1;
          end
          mic_pkg::ST_DUMMY1: begin
            state_r         <= mic_pkg::ST_DUMMY2;
            coreCmd.loadVec <= 1'b1;
          end
          mic_pkg::ST_DUMMY2: begin
            state_r       <= mic_pkg::ST_IDLE;
            coreCmd.dummy <= 1'b0;
          end
        endcase
      end
    end
  end

  // AXI read channel
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= mic_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mic_pkg::RESP_OKAY;
        unique case (s_axi_araddr[11:2])
          mic_pkg::IDX_OPTION: s_axi_rdata <= {24'h000000, optCfg_r};
          mic_pkg::IDX_CTRL:   s_axi_rdata <= {24'h000000, intrCtl_r};
          mic_pkg::IDX_PFLAGS: s_axi_rdata <= {24'h000000, perFlags_r};
          mic_pkg::IDX_PENAB:  s_axi_rdata <= {24'h000000, perEnab_r};
          mic_pkg::IDX_STATUS: s_axi_rdata <= {26'h0000000, coreEvt.sleepActive,
                                               coreCmd.wake, state_r, nopHold_r,
                                               coreCmd.irqReq};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= mic_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstnInt);

  sequence entryWalk;
    ##5 coreCmd.pushRet ##4 coreCmd.loadVec ##4 (state_r == mic_pkg::ST_IDLE);
  endsequence

  entry_timing_a: assert property (take |-> entryWalk)
    else $error("entry sequence timing wrong");
  gie_clear_entry_a: assert property (take |=> !intrCtl_r[mic_pkg::GIE_BIT])
    else $error("global enable not cleared on entry");
  ret_sets_gie_a: assert property (coreEvt.retExec && !take |=> intrCtl_r[mic_pkg::GIE_BIT])
    else $error("return did not set global enable");
  ext_flag_set_a: assert property (extEdge |=> intrCtl_r[mic_pkg::EXTF_BIT])
    else $error("external flag missed");
  t0_flag_set_a: assert property (coreEvt.timer0Roll |=> intrCtl_r[mic_pkg::T0F_BIT])
    else $error("timer flag missed");
  no_req_gated_a: assert property (!intrCtl_r[mic_pkg::GIE_BIT] |=> !coreCmd.irqReq)
    else $error("request while globally disabled");
  nop_after_clr_a: assert property (gieClrEvt |-> ##[1:5] coreCmd.nop)
    else $error("no-op not inserted");
  wake_sleep_a: assert property (wakeCond |=> coreCmd.wake)
    else $error("wake not raised");
  flag_kept_a: assert property (take |=> $stable(perFlags_r) || $past(wrFlags)
                                 || $past(|coreEvt.periphEvt))
    else $error("entry cleared a flag");
  dummy_span_a: assert property ($rose(coreCmd.dummy) |-> coreCmd.dummy [*8])
    else $error("dummy span too short");
endmodule : mic_irq_ctrl
`default_nettype wire

// file: mic_core_model.sv
// Purpose: Core sequencer and event source model facing the controller.
// Assumes: Events are launched just after a clock edge and last one clock.
// Notes:   Counts entry commands and wakes; a wake ends sleep.
`timescale 1ns/1ns
`default_nettype none
module mic_core_model (
  input  wire logic                   clk,
  input  wire mic_pkg::mic_core_cmd_t coreCmd,
  output var  mic_pkg::mic_core_evt_t coreEvt
);
  int          cyc     = 0;
  int          pushCnt = 0;
  int          vecCnt  = 0;
  int          nopCnt  = 0;
  int          wakeCnt = 0;
  int          pushAt  = 0;
  int          vecAt   = 0;
  logic [12:0] lastVec = 13'h0000;

  // Quiet events at start
  initial coreEvt = '0;

  // Stack push, vector load, no-op and wake bookkeeping
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (coreCmd.pushRet === 1'b1) begin
      pushCnt <= pushCnt + 1;
      pushAt  <= cyc;
    end
    if (coreCmd.loadVec === 1'b1) begin
      vecCnt  <= vecCnt + 1;
      vecAt   <= cyc;
      lastVec <= coreCmd.vecAddr;
    end
    if (coreCmd.nop === 1'b1) nopCnt <= nopCnt + 1;
    if (coreEvt.sleepActive && coreCmd.wake === 1'b1) begin
      wakeCnt             <= wakeCnt + 1;
      coreEvt.sleepActive <= 1'b0;  // Sleep ends, code resumes
    end
  end

  // Enter sleep, settled before the next pulse
  task automatic sleep();
    coreEvt.sleepActive <= 1'b1;
    @(posedge clk);
  endtask : sleep

  // One-clock event pulse, sleep level kept
  task automatic pulse(input mic_pkg::mic_core_evt_t e);
    e.sleepActive = coreEvt.sleepActive;
    coreEvt <= e;
    @(posedge clk);
    coreEvt <= {4'h0, e.sleepActive, 8'h00};
  endtask : pulse
endmodule : mic_core_model
`default_nettype wire

// file: mic_irq_ctrl_tb.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Registers over AXI4-Lite; core side is mic_core_model.
// Notes:   Each scenario drives the block and judges what comes back.
`timescale 1ns/1ns
`default_nettype none
module mic_irq_ctrl_tb;
  localparam logic [11:0] A_OPT = {mic_pkg::IDX_OPTION, 2'b00};
  localparam logic [11:0] A_CTL = {mic_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_PFL = {mic_pkg::IDX_PFLAGS, 2'b00};
  localparam logic [11:0] A_PEN = {mic_pkg::IDX_PENAB, 2'b00};
  localparam logic [1:0]  OK    = mic_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR   = mic_pkg::RESP_SLVERR;
  localparam mic_pkg::mic_core_evt_t E_T0  = 13'h1000;
  localparam mic_pkg::mic_core_evt_t E_RET = 13'h0800;
  localparam mic_pkg::mic_core_evt_t E_CLR = 13'h0400;
  localparam mic_pkg::mic_core_evt_t E_RD  = 13'h0200;
  localparam mic_pkg::mic_core_evt_t E_P0  = 13'h0001;
  logic                   clk           = 1'b0;
  logic                   rstn          = 1'b0;
  logic                   extIrqPin     = 1'b0;
  logic [3:0]             portPins      = 4'h0;
  logic [11:0]            s_axi_awaddr  = 12'h000;
  logic [11:0]            s_axi_araddr  = 12'h000;
  logic [31:0]            s_axi_wdata   = 32'h00000000;
  logic [3:0]             s_axi_wstrb   = 4'hF;
  logic                   s_axi_awvalid = 1'b0;
  logic                   s_axi_wvalid  = 1'b0;
  logic                   s_axi_bready  = 1'b0;
  logic                   s_axi_arvalid = 1'b0;
  logic                   s_axi_rready  = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                   s_axi_arready, s_axi_rvalid;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic [31:0]            s_axi_rdata;
  mic_pkg::mic_core_evt_t coreEvt;
  mic_pkg::mic_core_cmd_t coreCmd;
  int                     n_fail   = 0;
  int                     compares = 0;
  int                     guard    = 0;

  // Device and core model
  mic_irq_ctrl uut (.clk, .rstn, .extIrqPin, .portPins, .coreEvt, .coreCmd,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  mic_core_model core (.clk, .coreCmd, .coreEvt);

  // Clock
  always #25 clk = ~clk;

  // Verdict and end of run
  task automatic final_report();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // One clock of a bounded wait
  task automatic step();
    @(posedge clk);
    guard++;
    if (guard > 400) begin
      n_fail++;
      $display("Error wait expected 400 seen %0d", guard);
      final_report();
    end
  endtask : step

  // Write one register, address and data offered together
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    guard = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      step();
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : axi_wr

  // Read one register and compare it
  task automatic axi_rd(input string nm, input logic [11:0] a, input logic [7:0] ed,
                        input logic [1:0] er);
    guard = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      step();
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(nm, {24'h0, ed}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : axi_rd

  // Wait for the next vector load
  task automatic wait_vec(input int n0);
    guard = 0;
    while (core.vecCnt == n0) step();
  endtask : wait_vec

  // Reset values and an unmapped place
  task automatic t_reset();
    axi_rd("option", A_OPT, mic_pkg::RST_OPTION, OK);
    axi_rd("control", A_CTL, mic_pkg::RST_CTRL, OK);
    axi_rd("pflags", A_PFL, mic_pkg::RST_PFLAGS, OK);
    axi_rd("penab", A_PEN, mic_pkg::RST_PENAB, OK);
    axi_rd("status", {mic_pkg::IDX_STATUS, 2'b00}, 8'h00, OK);
    s_axi_wstrb <= 4'h0;
    axi_wr(A_OPT, 8'h00, OK);
    s_axi_wstrb <= 4'hF;
    axi_rd("option strobe", A_OPT, mic_pkg::RST_OPTION, OK);
    axi_rd("unmapped", 12'h004, 8'h00, ERR);
    axi_wr(12'h004, 8'h5A, ERR);
  endtask : t_reset

  // Flags set with every enable clear
  task automatic t_flags();
    core.pulse(E_T0 | 13'h00FF);
    axi_rd("control", A_CTL, 8'h04, OK);
    axi_rd("pflags", A_PFL, mic_pkg::PERIPH_MASK, OK);
    chk("irqReq", 0, coreCmd.irqReq);
    axi_wr(A_CTL, 8'h00, OK);
    axi_wr(A_PFL, 8'h00, OK);
  endtask : t_flags

  // Synchronous source taken: vector, stack, latency
  task automatic t_entry();
    int t0;
    axi_wr(A_CTL, 8'hA0, OK);
    core.pulse(E_T0);
    t0 = core.cyc;
    wait_vec(0);
    chk("latency", 1, core.vecAt - t0 >= 9 && core.vecAt - t0 <= 14);
    chk("push to vector", 4, core.vecAt - core.pushAt);
    chk("vector", mic_pkg::VECTOR_ADDR, core.lastVec);
    chk("pushes", 1, core.pushCnt);
    axi_rd("control", A_CTL, 8'h24, OK);
  endtask : t_entry

  // Pending flag re-enters after return; cleared flag does not
  task automatic t_return();
    core.pulse(E_RET);
    wait_vec(1);
    axi_wr(A_CTL, 8'h20, OK);
    core.pulse(E_RET);
    repeat (20) @(posedge clk);
    chk("entries", 2, core.vecCnt);
    axi_rd("control", A_CTL, 8'hA0, OK);
  endtask : t_return

  // Enable cleared by an instruction: no-op, request kept
  task automatic t_nop();
    int n0;
    n0 = core.nopCnt;
    core.pulse(E_T0 | E_CLR);
    repeat (12) @(posedge clk);
    chk("nop seen", 1, core.nopCnt > n0);
    chk("entries", 2, core.vecCnt);
    axi_rd("control", A_CTL, 8'h24, OK);
    core.pulse(E_RET);
    wait_vec(2);
    axi_wr(A_CTL, 8'h00, OK);
  endtask : t_nop

  // Both edge selections, then the pin mask
  task automatic t_ext();
    for (int s = 1; s >= 0; s--) begin
      axi_wr(A_OPT, (s == 1) ? 8'hFF : 8'hBF, OK);
      for (int k = 0; k < 2; k++) begin
        extIrqPin <= ~extIrqPin;
        repeat (8) @(posedge clk);
        axi_rd("ext flag", A_CTL, (extIrqPin == s) ? 8'h02 : 8'h00, OK);
        axi_wr(A_CTL, 8'h00, OK);
      end
    end
    axi_wr(A_OPT, 8'hFF, OK);
    axi_wr(A_CTL, 8'h80, OK);
    extIrqPin <= 1'b1;
    repeat (16) @(posedge clk);
    chk("entries", 3, core.vecCnt);
    chk("irqReq", 0, coreCmd.irqReq);
    axi_wr(A_CTL, 8'h92, OK);
    wait_vec(3);
    extIrqPin <= 1'b0;
    axi_wr(A_CTL, 8'h00, OK);
  endtask : t_ext

  // Port change flag, then peripheral group gating
  task automatic t_port();
    core.pulse(E_RD);
    axi_wr(A_CTL, 8'h00, OK);
    portPins <= 4'h8;
    repeat (8) @(posedge clk);
    axi_rd("port flag", A_CTL, 8'h01, OK);
    core.pulse(E_RD);
    axi_wr(A_CTL, 8'h80, OK);
    axi_wr(A_PEN, 8'h01, OK);
    axi_rd("penab", A_PEN, 8'h01, OK);
    core.pulse(E_P0);
    repeat (16) @(posedge clk);
    chk("entries", 4, core.vecCnt);
    chk("irqReq", 0, coreCmd.irqReq);
    axi_wr(A_CTL, 8'hC0, OK);
    wait_vec(4);
    axi_rd("pflags", A_PFL, 8'h01, OK);
    axi_wr(A_PFL, 8'h00, OK);
    axi_wr(A_CTL, 8'h00, OK);
  endtask : t_port

  // Wake with enable clear stays in line; wake with it set vectors
  task automatic t_sleep();
    axi_wr(A_CTL, 8'h20, OK);
    core.sleep();
    core.pulse(E_T0);
    repeat (8) @(posedge clk);
    chk("wakes", 1, core.wakeCnt);
    chk("entries", 5, core.vecCnt);
    axi_wr(A_CTL, 8'h90, OK);
    core.sleep();
    extIrqPin <= 1'b1;
    wait_vec(5);
    chk("wakes", 2, core.wakeCnt);
  endtask : t_sleep

  // Reset, then every scenario in turn
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_flags();
    t_entry();
    t_return();
    t_nop();
    t_ext();
    t_port();
    t_sleep();
    final_report();
  end
endmodule : mic_irq_ctrl_tb
`default_nettype wire
